// *** agc_consts.vh ***
// Purpose: constants for the gain control loop block
// Assumes: byte wide registers, 8-bit register address
// Notes:   counts are in channel filter samples
`ifndef AGC_CONSTS_VH
`define AGC_CONSTS_VH
// ----------------------------------------
// register map
// ----------------------------------------
`define AGC_SETUP_ADDR      8'h1c
`define AGC_STATUS_ADDR     8'h3e
`define AGC_SETUP_RESET     8'h91
// ----------------------------------------
// field positions in agc_loop_setup
// ----------------------------------------
`define AGC_DEADBAND_HI     7
`define AGC_DEADBAND_LO     6
`define AGC_WAIT_HI         5
`define AGC_WAIT_LO         4
`define AGC_HOLD_HI         3
`define AGC_HOLD_LO         2
`define AGC_FILT_HI         1
`define AGC_FILT_LO         0
// ----------------------------------------
// gain hold settings
// ----------------------------------------
`define AGC_HOLD_NONE       2'h0
`define AGC_HOLD_SYNC       2'h1
`define AGC_HOLD_ANALOG     2'h2
`define AGC_HOLD_BOTH       2'h3
// ----------------------------------------
// timing and dead zones
// ----------------------------------------
`define AGC_WAIT_0          6'h08
`define AGC_WAIT_1          6'h10
`define AGC_WAIT_2          6'h18
`define AGC_WAIT_3          6'h20
`define AGC_AVG_BASE_SHIFT  3
`define AGC_OOK_AVG_SEL     2'h1
`define AGC_OOK_STEP_DB     5'h04
`define AGC_GAIN_MAX        3'h7
`define AGC_DZ0_LO          10'h001
`define AGC_DZ0_HI          10'h001
`define AGC_DZ1_LO          10'h001
`define AGC_DZ1_HI          10'h002
`define AGC_DZ2_LO          10'h002
`define AGC_DZ2_HI          10'h004
`define AGC_DZ3_LO          10'h002
`define AGC_DZ3_HI          10'h008
`endif

// *** agc_loop.v ***
// Purpose: automatic gain control loop with its setup register
// Assumes: sample inputs come from logic on ref_clk
// Notes:   magnitudes are treated as linear 8-bit values
//
// Notes on behaviour
// - two-bit dead zone select, reset 2, widens dead zone around target
// - after each gain step skip 8, 16, 24 or 32 samples; reset 16
// - hold setting 0 adjusts gain whenever the loop asks
// - hold setting 1 freezes gain once a sync word is found
// - hold setting 2 freezes analogue gain, digital gain keeps moving
// - hold setting 3 freezes both gains, allowing manual override
// - FSK and MSK: average amplitude over 8, 16, 32 or 64 samples
// - OOK and ASK: same field selects decision boundary 4 to 16 dB
`timescale 1ns/1ps
`include "agc_consts.vh"
module agc_loop
(
  input  wire       ref_clk,
  input  wire       rst_b,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  input  wire       sample_valid,
  input  wire [7:0] sample_mag,
  input  wire [7:0] magn_target,
  input  wire       ook_mode,
  input  wire       sync_found,
  input  wire       rx_restart,
  input  wire       manual_load,
  input  wire [2:0] manual_analog_gain,
  input  wire [2:0] manual_digital_gain,
  output reg  [2:0] analog_gain,
  output reg  [2:0] digital_gain,
  output reg  [7:0] amp_avg,
  output reg  [4:0] ook_boundary_db,
  output reg        settling
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  reg  [7:0]  setup_reg;
  reg         sync_seen_reg;
  reg  [5:0]  settle_cnt_reg;
  reg  [6:0]  acc_cnt_reg;
  reg  [13:0] acc_sum_reg;
  wire [1:0]  dz_sel   = setup_reg[`AGC_DEADBAND_HI:`AGC_DEADBAND_LO];
  wire [1:0]  wait_sel = setup_reg[`AGC_WAIT_HI:`AGC_WAIT_LO];
  wire [1:0]  hold_sel = setup_reg[`AGC_HOLD_HI:`AGC_HOLD_LO];
  wire [1:0]  filt_sel = setup_reg[`AGC_FILT_HI:`AGC_FILT_LO];
  // ----------------------------------------
  // register port
  // ----------------------------------------
  // a read in the cycle of a write returns the old value
  always @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      setup_reg <= `AGC_SETUP_RESET;
      reg_rdata <= 8'h00;
    end
    else
    begin
      if (reg_wr && reg_addr == `AGC_SETUP_ADDR)
        setup_reg <= reg_wdata;
      if (reg_rd)
      begin
        if (reg_addr == `AGC_SETUP_ADDR)
          reg_rdata <= setup_reg;
        else if (reg_addr == `AGC_STATUS_ADDR)
          reg_rdata <= {settling, sync_seen_reg, analog_gain, digital_gain};
        else
          reg_rdata <= 8'h00;
      end
    end
  end
  // ----------------------------------------
  // averaging and decision
  // ----------------------------------------
  // averaging length select
  // ook reception has no length field of its own, so a fixed length is used
  wire [1:0]  avg_sel   = ook_mode ? `AGC_OOK_AVG_SEL : filt_sel;
  wire [6:0]  avg_last  = (7'h08 << avg_sel) - 7'h01;
  // 64 samples of full scale still fit in 14 bits
  wire [13:0] sum_next  = acc_sum_reg + {6'h00, sample_mag};
  wire [13:0] avg_wide  = sum_next >> (`AGC_AVG_BASE_SHIFT + avg_sel);
  wire [7:0]  avg_now   = avg_wide[7:0];
  // ----------------------------------------
  // settle wait
  // ----------------------------------------
  reg  [5:0]  settle_len;
  always @*
  begin
    case (wait_sel)
      2'h0:
        settle_len = `AGC_WAIT_0;
      2'h1:
        settle_len = `AGC_WAIT_1;
      2'h2:
        settle_len = `AGC_WAIT_2;
      default:
        settle_len = `AGC_WAIT_3;
    endcase
  end
  // ----------------------------------------
  // dead zone
  // ----------------------------------------
  reg  [9:0]  dz_lo;
  reg  [9:0]  dz_hi;
  always @*
  begin
    case (dz_sel)
      2'h0:
      begin
        dz_lo = `AGC_DZ0_LO;
        dz_hi = `AGC_DZ0_HI;
      end
      2'h1:
      begin
        dz_lo = `AGC_DZ1_LO;
        dz_hi = `AGC_DZ1_HI;
      end
      2'h2:
      begin
        dz_lo = `AGC_DZ2_LO;
        dz_hi = `AGC_DZ2_HI;
      end
      default:
      begin
        dz_lo = `AGC_DZ3_LO;
        dz_hi = `AGC_DZ3_HI;
      end
    endcase
  end
  // compares are two bits wider so target plus dead zone cannot wrap
  wire too_strong = {2'h0, avg_now} > ({2'h0, magn_target} + dz_hi);
  wire too_weak   = ({2'h0, avg_now} + dz_lo) < {2'h0, magn_target};
  wire hold_all = (hold_sel == `AGC_HOLD_BOTH) || (hold_sel == `AGC_HOLD_SYNC && sync_seen_reg);
  wire hold_ana = hold_all || (hold_sel == `AGC_HOLD_ANALOG);
  wire block_end = sample_valid && settle_cnt_reg == 6'h00 && acc_cnt_reg == avg_last;
  // ----------------------------------------
  // gain loop
  // ----------------------------------------
  always @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      sync_seen_reg   <= 1'b0;
      settle_cnt_reg  <= 6'h00;
      acc_cnt_reg     <= 7'h00;
      acc_sum_reg     <= 14'h0000;
      analog_gain     <= `AGC_GAIN_MAX;
      digital_gain    <= `AGC_GAIN_MAX;
      amp_avg         <= 8'h00;
      ook_boundary_db <= `AGC_OOK_STEP_DB;
      settling        <= 1'b0;
    end
    else
    begin
      ook_boundary_db <= {3'h0, filt_sel} * `AGC_OOK_STEP_DB + `AGC_OOK_STEP_DB;
      // a sync event in the restart cycle still counts: set wins
      if (sync_found)
        sync_seen_reg <= 1'b1;
      else if (rx_restart)
        sync_seen_reg <= 1'b0;
      // registered flag, one cycle behind the counter
      settling <= settle_cnt_reg != 6'h00;
      if (sample_valid && settle_cnt_reg != 6'h00)
        settle_cnt_reg <= settle_cnt_reg - 6'h01;
      else if (sample_valid && !block_end)
      begin
        acc_sum_reg <= sum_next;
        acc_cnt_reg <= acc_cnt_reg + 7'h01;
      end
      else if (block_end)
      begin
        acc_sum_reg <= 14'h0000;
        acc_cnt_reg <= 7'h00;
        amp_avg     <= avg_now;
        // analogue stage first; digital only when analogue is held or at a limit
        // normal adjustment
        if (too_strong)
        begin
          if (!hold_ana && analog_gain != 3'h0)
          begin
            analog_gain    <= analog_gain - 3'h1;
            settle_cnt_reg <= settle_len;
          end
          else if (!hold_all && digital_gain != 3'h0)
          begin
            digital_gain   <= digital_gain - 3'h1;
            settle_cnt_reg <= settle_len;
          end
        end
        else if (too_weak)
        begin
          if (!hold_ana && analog_gain != `AGC_GAIN_MAX)
          begin
            analog_gain    <= analog_gain + 3'h1;
            settle_cnt_reg <= settle_len;
          end
          else if (!hold_all && digital_gain != `AGC_GAIN_MAX)
          begin
            digital_gain   <= digital_gain + 3'h1;
            settle_cnt_reg <= settle_len;
          end
        end
      end
      // last in the block so a manual load beats a loop step in the same cycle
      // manual override
      if (manual_load && hold_sel == `AGC_HOLD_BOTH)
      begin
        analog_gain  <= manual_analog_gain;
        digital_gain <= manual_digital_gain;
      end
    end
  end
endmodule

// *** agc_loop_monitor.sv ***
// Purpose: port checker for agc_loop
// Assumes: setup register shadowed from writes
// Notes:   manual loads excluded from step checks
`timescale 1ns/1ps
`include "agc_consts.vh"
module agc_monitor
(
  input wire logic       ref_clk,
  input wire logic       rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       sync_found,
  input wire logic       rx_restart,
  input wire logic       manual_load,
  input wire logic [2:0] analog_gain,
  input wire logic [2:0] digital_gain,
  input wire logic [4:0] ook_boundary_db,
  input wire logic       settling
);
  reg  [7:0] sh_reg;
  reg        seen_reg;
  wire [1:0] hold = sh_reg[3:2];
  wire [4:0] bnd  = {1'h0, sh_reg[1:0], 2'h0} + 5'h04;
  // ----------------------------------------
  // shadow state and properties
  // ----------------------------------------
  always @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      sh_reg   <= `AGC_SETUP_RESET;
      seen_reg <= 1'h0;
    end
    else
    begin
      if (reg_wr && reg_addr == `AGC_SETUP_ADDR)
        sh_reg <= reg_wdata;
      seen_reg <= sync_found | (seen_reg & ~rx_restart);
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // past reset guard: a short reset would otherwise look like a gain step
  setup_read_a: assert property (reg_rd && reg_addr == `AGC_SETUP_ADDR |=> reg_rdata == $past(sh_reg))
    else $error("setup readback wrong");
  one_step_a: assert property ($past(rst_b) && $changed(analog_gain) && !$past(manual_load)
    |-> $stable(digital_gain)
    && (analog_gain == $past(analog_gain) - 3'h1 || analog_gain == $past(analog_gain) + 3'h1))
    else $error("bad gain step");
  step_settles_a: assert property ($past(rst_b) && ($changed(analog_gain) || $changed(digital_gain))
    && !$past(manual_load) |=> settling) else $error("no settling after step");
  settle_hold_a: assert property (settling && !manual_load |=> $stable(analog_gain) && $stable(digital_gain))
    else $error("gain moved while settling");
  sync_hold_a: assert property (hold == 2'h1 && seen_reg |=> $stable(analog_gain) && $stable(digital_gain))
    else $error("gain moved after sync");
  analog_held_a: assert property (hold == 2'h2 |=> $stable(analog_gain))
    else $error("analogue gain moved");
  both_held_a: assert property (hold == 2'h3 && !manual_load |=> $stable(analog_gain) && $stable(digital_gain))
    else $error("gains moved while held");
  ook_bound_a: assert property ($past(rst_b) |-> ook_boundary_db == $past(bnd))
    else $error("decision boundary wrong");
  cover property (hold == 2'h3 && manual_load);
  cover property ($rose(settling));
  cover property (hold == 2'h1 && seen_reg && $changed(digital_gain) == 1'h0);
endmodule
bind agc_loop agc_monitor u_mon
(
  .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sync_found(sync_found), .rx_restart(rx_restart),
  .manual_load(manual_load), .analog_gain(analog_gain), .digital_gain(digital_gain),
  .ook_boundary_db(ook_boundary_db), .settling(settling)
);

// *** testbench.sv ***
// Purpose: self-checking bench for agc_loop
// Assumes: target 0x40, manual gains 2 and 5
// Notes:   rows restart from reset so gains begin at 7
`timescale 1ns/1ps
`include "agc_consts.vh"
module testbench;
  reg        ref_clk, rst_b, reg_wr, reg_rd, sample_valid, ook_mode, sync_found, rx_restart, manual_load;
  reg  [7:0] reg_addr, reg_wdata, sample_mag;
  wire [7:0] reg_rdata, amp_avg;
  wire [2:0] analog_gain, digital_gain;
  wire [4:0] ook_boundary_db;
  wire       settling;
  integer    bad_count, comparisons, i;
  reg [31:0] rows [0:12];
  agc_loop dut
  (
    .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_valid(sample_valid), .sample_mag(sample_mag),
    .magn_target(8'h40), .ook_mode(ook_mode), .sync_found(sync_found), .rx_restart(rx_restart),
    .manual_load(manual_load), .manual_analog_gain(3'h2), .manual_digital_gain(3'h5),
    .analog_gain(analog_gain), .digital_gain(digital_gain), .amp_avg(amp_avg),
    .ook_boundary_db(ook_boundary_db), .settling(settling)
  );
  // ----------------------------------------
  // clock, tasks and sequence
  // ----------------------------------------
  initial
  begin
    ref_clk = 1'h0;
    forever #2 ref_clk = ~ref_clk;
  end
  task chk(input [7:0] seen, input [7:0] exp);
  begin
    comparisons = comparisons + 1;
    if (seen !== exp)
    begin
      bad_count = bad_count + 1;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  end
  endtask
  task give_verdict;
  begin
    if (bad_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask
  task wr(input [7:0] a, input [7:0] d);
  begin
    @(posedge ref_clk) {reg_wr, reg_addr, reg_wdata} <= {1'h1, a, d};
    @(posedge ref_clk) reg_wr <= 1'h0;
  end
  endtask
  task rd(input [7:0] a, input [7:0] exp);
  begin
    @(posedge ref_clk) {reg_rd, reg_addr} <= {1'h1, a};
    @(posedge ref_clk) reg_rd <= 1'h0;
    @(negedge ref_clk) chk(reg_rdata, exp);
  end
  endtask
  task rst(input [7:0] s);
  begin
    @(posedge ref_clk) rst_b <= 1'h0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'h1;
    wr(`AGC_SETUP_ADDR, s);
  end
  endtask
  // back-to-back samples: the worst case for the settle count
  task feed(input [7:0] m, input [7:0] n);
  begin
    @(posedge ref_clk) {sample_valid, sample_mag} <= {1'h1, m};
    repeat (n) @(posedge ref_clk);
    sample_valid <= 1'h0;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
  end
  endtask
  initial
  begin
    {rst_b, reg_wr, reg_rd, sample_valid, ook_mode, sync_found, rx_restart, manual_load} = 8'h0;
    {reg_addr, reg_wdata, sample_mag} = 24'h0;
    bad_count = 0;
    comparisons = 0;
    rows[0] = 32'h91451067;
    rows[1] = 32'h91441077;
    rows[2] = 32'h11421067;
    rows[3] = 32'hd1481077;
    rows[4] = 32'h99501076;
    rows[5] = 32'h9d501077;
    rows[6] = 32'h90500867;
    rows[7] = 32'h93504067;
    rows[8] = 32'h81502857;
    rows[9] = 32'hb1504057;
    rows[10] = 32'h92502067;
    rows[11] = 32'ha1503857;
    rows[12] = 32'h51431067;
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'h1;
    rd(`AGC_SETUP_ADDR, `AGC_SETUP_RESET);
    rd(8'h55, 8'h00);
    for (i = 0; i < 13; i = i + 1)
    begin
      rst(rows[i][31:24]);
      feed(rows[i][23:16], rows[i][15:8]);
      chk(analog_gain, rows[i][6:4]);
      chk(digital_gain, rows[i][2:0]);
      chk(amp_avg, rows[i][23:16]);
    end
    @(posedge ref_clk) ook_mode <= 1'h1;
    rst(8'h90);
    for (i = 0; i < 4; i = i + 1)
    begin
      wr(`AGC_SETUP_ADDR, 8'h90 + i[7:0]);
      @(posedge ref_clk);
      @(negedge ref_clk) chk(ook_boundary_db, 8'h04 * (i + 1));
    end
    feed(8'h60, 8'h10);
    chk(amp_avg, 8'h60);
    @(posedge ref_clk) ook_mode <= 1'h0;
    rst(8'h95);
    @(posedge ref_clk) sync_found <= 1'h1;
    @(posedge ref_clk) sync_found <= 1'h0;
    feed(8'h50, 8'h10);
    chk(analog_gain, 8'h07);
    @(posedge ref_clk) rx_restart <= 1'h1;
    @(posedge ref_clk) rx_restart <= 1'h0;
    feed(8'h50, 8'h10);
    chk(analog_gain, 8'h06);
    feed(8'h30, 8'h20);
    chk(analog_gain, 8'h07);
    wr(`AGC_SETUP_ADDR, 8'h9d);
    @(posedge ref_clk) manual_load <= 1'h1;
    @(posedge ref_clk) manual_load <= 1'h0;
    @(negedge ref_clk) chk({analog_gain, digital_gain}, 8'h15);
    rd(`AGC_STATUS_ADDR, 8'h95);
    give_verdict;
  end
  // about 650 cycles expected; allow far more before cutting a hang
  initial
  begin
    #100000;
    bad_count = bad_count + 1;
    give_verdict;
  end
endmodule
